// file: rtl/scfg_top.sv
/*
 * Strap configuration latch with register mirror and MDI pair mirror.
 * Assumes an analog front end giving comparator levels per strap pin,
 * a classic Wishbone master, and a speed indication on gig_mode_i.
 */
// Summary of operation
// - Straps are captured only after power-up or hard reset, then held.
// - Soft reset reloads settings from held straps without resampling.
// - Each strap resolves to one of four modes, codes 00 to 11.
// - Lane 0 strap sets address bits 1:0, lane 2 bits 3:2.
// - Control strap mode 3 clears, mode 4 sets autoneg disable.
// - Pin zero strap: mode 1 gives rx skew bit 0 low, mode 3 high.
// - Pin one strap sets rx skew 2:1; indicator two sets tx skew 1:0.
// - Indicator one: advertise select, tx skew 2; zero: mirror, SGMII.
// - Every strap setting is also writable over the register bus.
// - Mirroring follows its strap bit or config four mirror bit.
// - Mirror at 10/100 maps pair A to D and B to C.
// - Mirror at gigabit swaps A with D and B with C both ways.
// - With no resistors fitted the address comes up as zero.
// - Advertise select 0 offers 10/100/1000, 1 offers 100/1000 only.
// - Skew code selects delay in half-nanosecond steps.
`timescale 1ns/1ps
`include "scfg_params.svh"

module scfg_top
	import scfg_pkg::*;
#(
	parameter int LANE_W = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Strap comparator levels
	input wire logic [2:0] rx_lane0_strap_i,
	input wire logic [2:0] rx_lane2_strap_i,
	input wire logic [2:0] rx_ctrl_strap_i,
	input wire logic [2:0] gpio0_strap_i,
	input wire logic [2:0] gpio1_strap_i,
	input wire logic [2:0] indicator_pin_two_i,
	input wire logic [2:0] indicator_pin_one_i,
	input wire logic [2:0] indicator_pin_zero_i,
	// Configuration outputs
	output logic [3:0] station_addr_o,
	output logic aneg_disable_o,
	output logic [2:0] adv_ability_o,
	output logic [2:0] rx_skew_o,
	output logic [2:0] tx_skew_o,
	output logic [2:0] rx_delay_o,
	output logic [2:0] tx_delay_o,
	output logic mirror_en_o,
	output logic sgmii_en_o,
	// MDI lanes
	input wire logic gig_mode_i,
	input wire logic [3:0][LANE_W-1:0] tx_lane_i,
	input wire logic [3:0][LANE_W-1:0] rx_lane_i,
	output logic [3:0][LANE_W-1:0] tx_phy_o,
	output logic [3:0][LANE_W-1:0] rx_log_o
);

	localparam int NS = `SCFG_NSTRAP;

	logic [NS*3-1:0] lvl_w;
	logic [NS*2-1:0] code_w;
	scfg_cap_e cap_q;
	logic [1:0] settle_q;
	logic [NS*2-1:0] strap_q;
	logic cap_load_w;
	logic reload_w;
	logic soft_q;
	logic [NS*2-1:0] src_w;
	scfg_code_t lane0_w;
	scfg_code_t lane2_w;
	scfg_code_t ctl_w;
	scfg_code_t gp0_w;
	scfg_code_t gp1_w;
	scfg_code_t ind2_w;
	scfg_code_t ind1_w;
	scfg_code_t ind0_w;
	logic [3:0] addr_dflt_w;
	logic [10:0] cfg_dflt_w;
	logic [7:0] cfg_four_dflt_w;
	logic [3:0] addr_q;
	logic [10:0] cfg_q;
	logic [7:0] cfg_four_q;
	logic ctl_bad_w;
	logic gp0_bad_w;
	logic ack_q;
	logic take_w;
	logic wr_w;
	logic [5:0] widx_w;
	logic hit_ctrl_w;
	logic hit_addr_w;
	logic hit_cfg_w;
	logic hit_strap_w;
	logic hit_delay_w;
	logic hit_cfg_four_w;
	logic [31:0] m_ctrl_w;
	logic [31:0] m_addr_w;
	logic [31:0] m_cfg_w;
	logic [31:0] m_cfg_four_w;
	logic [31:0] rd_w;

	// Strap slot order, slot 0 in the low bits
	assign lvl_w = {indicator_pin_zero_i, indicator_pin_one_i,
		indicator_pin_two_i, gpio1_strap_i, gpio0_strap_i,
		rx_ctrl_strap_i, rx_lane2_strap_i, rx_lane0_strap_i};

	scfg_strap_in #(
		.N(NS)
	) u_strap (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.lvl_i(lvl_w),
		.code_o(code_w)
	);

	// Capture waits out the synchroniser before the one-time latch
	assign cap_load_w = (cap_q == CAP_WAIT) && (settle_q == `SCFG_SETTLE);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cap_q <= CAP_WAIT;
			settle_q <= 2'h0;
		end else begin
			unique case (cap_q)
				CAP_WAIT: begin
					if (cap_load_w)
						cap_q <= CAP_HELD;
					else
						settle_q <= settle_q + 2'h1;
				end
				CAP_HELD: cap_q <= CAP_HELD;
			endcase
		end
	end

	// Held strap codes; soft reset never touches them
	always_ff @(posedge clk_i) begin
		if (rst_i)
			strap_q <= '0;
		else if (cap_load_w)
			strap_q <= code_w;
	end

	// Defaults come from fresh codes on capture, held ones otherwise
	assign reload_w = cap_load_w | soft_q;
	assign src_w = cap_load_w ? code_w : strap_q;
	assign lane0_w = src_w[1:0];
	assign lane2_w = src_w[3:2];
	assign ctl_w = src_w[5:4];
	assign gp0_w = src_w[7:6];
	assign gp1_w = src_w[9:8];
	assign ind2_w = src_w[11:10];
	assign ind1_w = src_w[13:12];
	assign ind0_w = src_w[15:14];

	// Strap codes distributed to setting fields
	assign addr_dflt_w = {lane2_w, lane0_w};
	assign cfg_dflt_w = {
		ind1_w[0], ind2_w,
		1'b0,
		gp1_w, gp0_w[1],
		1'b0,
		ind0_w[0], ind1_w[1],
		&ctl_w
	};
	assign cfg_four_dflt_w = `SCFG_CFG_FOUR_RST |
		{7'h00, ind0_w[1]};

	// Invalid mode flags for the two restricted straps
	assign ctl_bad_w = ~strap_q[5];
	assign gp0_bad_w = strap_q[6];

	// Bus decode; one wait state, every address answers
	// Writes land on the ack edge, while the request still stands
	assign take_w = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr_w = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
	assign widx_w = wb_adr_i[7:2];
	assign hit_ctrl_w = widx_w == `SCFG_IDX_CTRL;
	assign hit_addr_w = widx_w == `SCFG_IDX_ADDR;
	assign hit_cfg_w = widx_w == `SCFG_IDX_CFG;
	assign hit_strap_w = widx_w == `SCFG_IDX_STRAP;
	assign hit_delay_w = widx_w == `SCFG_IDX_DELAY;
	assign hit_cfg_four_w = widx_w == `SCFG_IDX_CFG_FOUR;

	// Byte-lane merged write values
	assign m_ctrl_w = scfg_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
	assign m_addr_w = scfg_merge({28'h0, addr_q}, wb_dat_i, wb_sel_i);
	assign m_cfg_w = scfg_merge({21'h0, cfg_q}, wb_dat_i, wb_sel_i);
	assign m_cfg_four_w = scfg_merge({24'h0, cfg_four_q}, wb_dat_i,
		wb_sel_i);

	// Read mux; soft reset bit reads back zero
	assign rd_w = hit_addr_w ? {28'h0, addr_q} :
		hit_cfg_w ? {21'h0, cfg_q} :
		hit_strap_w ? {14'h0, gp0_bad_w, ctl_bad_w, strap_q} :
		hit_delay_w ? {25'h0, rx_delay_o, 1'b0, tx_delay_o} :
		hit_cfg_four_w ? {24'h0, cfg_four_q} : 32'h0000_0000;

	// Handshake: ack for one cycle, data registered with it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			ack_q <= take_w;
			wb_dat_o <= take_w ? rd_w : 32'h0000_0000;
		end
	end
	assign wb_ack_o = ack_q;

	// Soft reset is a one-cycle pulse, acted on next cycle
	always_ff @(posedge clk_i) begin
		if (rst_i)
			soft_q <= 1'b0;
		else
			soft_q <= wr_w & hit_ctrl_w & m_ctrl_w[`SCFG_CTRL_SOFT];
	end

	// Settings: strap defaults on reload, software may overwrite
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_q <= `SCFG_ADDR_RST;
			cfg_q <= `SCFG_CFG_RST;
			cfg_four_q <= `SCFG_CFG_FOUR_RST;
		end else if (reload_w) begin
			addr_q <= addr_dflt_w;
			cfg_q <= cfg_dflt_w;
			cfg_four_q <= cfg_four_dflt_w;
		end else if (wr_w) begin
			if (hit_addr_w)
				addr_q <= m_addr_w[3:0];
			if (hit_cfg_w)
				cfg_q <= m_cfg_w[10:0];
			if (hit_cfg_four_w)
				cfg_four_q <= m_cfg_four_w[7:0];
		end
	end

	// Output stage; a cleared config four bit 7 masks autoneg disable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			station_addr_o <= `SCFG_ADDR_RST;
			aneg_disable_o <= 1'b0;
			adv_ability_o <= `SCFG_ADV_ALL;
			rx_skew_o <= 3'h0;
			tx_skew_o <= 3'h0;
			rx_delay_o <= 3'h0;
			tx_delay_o <= 3'h0;
			mirror_en_o <= 1'b0;
			sgmii_en_o <= 1'b0;
		end else begin
			station_addr_o <= addr_q;
			aneg_disable_o <= cfg_q[`SCFG_CFG_ANEG] &
				cfg_four_q[`SCFG_CFG_FOUR_ANOK];
			adv_ability_o <= cfg_q[`SCFG_CFG_ADV] ?
				`SCFG_ADV_FAST : `SCFG_ADV_ALL;
			rx_skew_o <= cfg_q[`SCFG_CFG_RX];
			tx_skew_o <= cfg_q[`SCFG_CFG_TX];
			rx_delay_o <= scfg_skew_steps(cfg_q[`SCFG_CFG_RX]);
			tx_delay_o <= scfg_skew_steps(cfg_q[`SCFG_CFG_TX]);
			mirror_en_o <= cfg_four_q[`SCFG_CFG_FOUR_MIR];
			sgmii_en_o <= cfg_q[`SCFG_CFG_SGMII];
		end
	end

	// Mirror map follows the registered enable
	scfg_mirror #(
		.W(LANE_W)
	) u_mirror (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.en_i(mirror_en_o),
		.gig_i(gig_mode_i),
		.tx_log_i(tx_lane_i),
		.rx_phy_i(rx_lane_i),
		.tx_phy_o(tx_phy_o),
		.rx_log_o(rx_log_o)
	);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence rst_done_s;
		$fell(rst_i);
	endsequence

	sequence soft_pulse_s;
		wr_w && hit_ctrl_w && m_ctrl_w[`SCFG_CTRL_SOFT] ##1 soft_q;
	endsequence

	cap_timing_a: assert property (
		rst_done_s |-> ##2 cap_load_w ##1 cap_q == CAP_HELD)
		else $error("strap capture not two cycles after reset");
	strap_hold_a: assert property (
		cap_q == CAP_HELD |=> $stable(strap_q))
		else $error("held strap codes changed");
	soft_reload_a: assert property (
		soft_pulse_s |=> $stable(strap_q) && addr_q == strap_q[3:0])
		else $error("soft reset did not reload held straps");
	addr_map_a: assert property (
		cap_load_w |=> addr_q == {$past(lane2_w), $past(lane0_w)}
		##1 station_addr_o == $past(addr_q))
		else $error("station address not taken from straps");
	aneg_map_a: assert property (
		cap_load_w |=> cfg_q[`SCFG_CFG_ANEG] == ($past(ctl_w) == 2'h3))
		else $error("autoneg disable strap decoded wrong");
	aneg_gate_a: assert property (
		!cfg_four_q[`SCFG_CFG_FOUR_ANOK] |=> !aneg_disable_o)
		else $error("autoneg disable not masked by config four");
	skew_map_a: assert property (
		cap_load_w |=> cfg_q[`SCFG_CFG_TX] == $past({ind1_w[0], ind2_w})
		&& cfg_q[`SCFG_CFG_RX] == $past({gp1_w, gp0_w[1]})
		&& cfg_q[`SCFG_CFG_ADV] == $past(ind1_w[1]))
		else $error("skew or advertise strap decoded wrong");
	cfg_write_a: assert property (
		wr_w && hit_cfg_w && wb_sel_i == 4'hF && !reload_w
		|=> cfg_q == $past(wb_dat_i[10:0]) ##1 wb_ack_o == 1'b0)
		else $error("configuration write not stored");
	mirror_src_a: assert property (
		cap_load_w |=> cfg_four_q[`SCFG_CFG_FOUR_MIR] == $past(ind0_w[1])
		##1 mirror_en_o == $past(cfg_four_q[`SCFG_CFG_FOUR_MIR]))
		else $error("mirror enable not taken from strap");
	adv_out_a: assert property (
		cfg_q[`SCFG_CFG_ADV] |=> adv_ability_o == `SCFG_ADV_FAST)
		else $error("advertise select did not drop 10M");
	tx_delay_a: assert property (
		cfg_q[`SCFG_CFG_TX] == 3'h0 |=> tx_delay_o == 3'h4)
		else $error("tx skew code 000 is not 2.0 ns");
	ack_once_a: assert property (
		take_w |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not a single cycle");

endmodule : scfg_top

// file: rtl/scfg_params.svh
/*
 * Constants of the strap configuration block: register word indices,
 * field positions, reset values and strap slot numbers.
 * Assumes byte addressing on the bus, one 32-bit word per register.
 */
`ifndef SCFG_PARAMS_SVH
`define SCFG_PARAMS_SVH

// Word indices (byte address is four times the index)
`define SCFG_IDX_CTRL 6'h00
`define SCFG_IDX_ADDR 6'h01
`define SCFG_IDX_CFG 6'h02
`define SCFG_IDX_STRAP 6'h03
`define SCFG_IDX_DELAY 6'h04
`define SCFG_IDX_CFG_FOUR 6'h31

// Control register: self-clearing global soft reset
`define SCFG_CTRL_SOFT 15

// General configuration fields
`define SCFG_CFG_ANEG 0
`define SCFG_CFG_ADV 1
`define SCFG_CFG_SGMII 2
`define SCFG_CFG_RX 6:4
`define SCFG_CFG_TX 10:8

// Configuration register four fields
`define SCFG_CFG_FOUR_MIR 0
`define SCFG_CFG_FOUR_ANOK 7

// Reset values
`define SCFG_ADDR_RST 4'h0
`define SCFG_CFG_RST 11'h000
`define SCFG_CFG_FOUR_RST 8'h80
`define SCFG_ADV_ALL 3'h7
`define SCFG_ADV_FAST 3'h6

// Strap slots and capture timing
`define SCFG_NSTRAP 8
`define SCFG_SETTLE 2'h2

`endif

// file: rtl/scfg_pkg.sv
/*
 * Types and helper functions of the strap configuration block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package scfg_pkg;

	typedef logic [1:0] scfg_code_t;

	// Strap capture state after a hard reset
	typedef enum logic {CAP_WAIT, CAP_HELD} scfg_cap_e;

	// Comparator thermometer to mode code; a bad bubble rounds up
	function automatic scfg_code_t scfg_level(input logic [2:0] t);
		if (t[2])
			return 2'h3;
		else if (t[1])
			return 2'h2;
		else if (t[0])
			return 2'h1;
		else
			return 2'h0;
	endfunction : scfg_level

	// Skew code to delay in half-nanosecond steps
	function automatic logic [2:0] scfg_skew_steps(input logic [2:0] c);
		case (c)
			3'h0: return 3'h4;
			3'h1: return 3'h3;
			3'h2: return 3'h2;
			3'h3: return 3'h1;
			3'h4: return 3'h0;
			3'h5: return 3'h7;
			3'h6: return 3'h6;
			default: return 3'h5;
		endcase
	endfunction : scfg_skew_steps

	// Byte-lane merge of a bus write into an old value
	function automatic logic [31:0] scfg_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b])
				r[b*8 +: 8] = wd[b*8 +: 8];
		end
		return r;
	endfunction : scfg_merge

endpackage : scfg_pkg

// file: rtl/scfg_strap_in.sv
/*
 * Strap input stage: two-flop synchronisers and level decoding.
 * Assumes each strap arrives as a 3-bit comparator thermometer.
 */
`timescale 1ns/1ps

module scfg_strap_in
	import scfg_pkg::*;
#(
	parameter int N = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Raw comparator levels, three per strap
	input wire logic [N*3-1:0] lvl_i,
	// Decoded two-bit mode codes
	output logic [N*2-1:0] code_o
);

	logic [N*3-1:0] meta_q;
	logic [N*3-1:0] sync_q;

	// Zero on reset reads as mode 1, as with no resistors fitted
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= lvl_i;
			sync_q <= meta_q;
		end
	end

	// Only the second stage feeds the decoders
	for (genvar i = 0; i < N; i++) begin : g_dec
		assign code_o[i*2 +: 2] = scfg_level(sync_q[i*3 +: 3]);
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	top_level_a: assert property (
		(lvl_i[2:0] == 3'h7) [*3] |-> code_o[1:0] == 2'h3)
		else $error("full-scale strap did not decode to mode 4");
	open_pin_a: assert property (
		(lvl_i[2:0] == 3'h0) [*3] |-> code_o[1:0] == 2'h0)
		else $error("open strap did not decode to mode 1");

endmodule : scfg_strap_in

// file: rtl/scfg_mirror.sv
/*
 * MDI pair mirror: maps logical pairs A..D onto physical pairs.
 * Assumes lane 0 is pair A and lane 3 is pair D on both sides.
 */
`timescale 1ns/1ps

module scfg_mirror #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Mode
	input wire logic en_i,
	input wire logic gig_i,
	// Logical transmit and physical receive lanes
	input wire logic [3:0][W-1:0] tx_log_i,
	input wire logic [3:0][W-1:0] rx_phy_i,
	// Physical transmit and logical receive lanes
	output logic [3:0][W-1:0] tx_phy_o,
	output logic [3:0][W-1:0] rx_log_o
);

	logic [3:0][W-1:0] tx_w;
	logic [3:0][W-1:0] rx_w;

	// Straight and crossover map the same way, so no MDI mode input
	for (genvar p = 0; p < 4; p++) begin : g_lane
		assign tx_w[p] = !en_i ? tx_log_i[p] :
			(gig_i || p >= 2) ? tx_log_i[3-p] : {W{1'b0}};
		assign rx_w[p] = !en_i ? rx_phy_i[p] :
			(gig_i || p <= 1) ? rx_phy_i[3-p] : {W{1'b0}};
	end

	// Registered so the top drives lanes from flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_phy_o <= '0;
			rx_log_o <= '0;
		end else begin
			tx_phy_o <= tx_w;
			rx_log_o <= rx_w;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	gig_swap_a: assert property (
		en_i && gig_i |=> tx_phy_o[0] == $past(tx_log_i[3]) &&
		rx_log_o[1] == $past(rx_phy_i[2]))
		else $error("gigabit mirror swap wrong");
	fast_map_a: assert property (
		en_i && !gig_i |=> tx_phy_o[3] == $past(tx_log_i[0]) &&
		tx_phy_o[2] == $past(tx_log_i[1]))
		else $error("10/100 mirror map wrong");

endmodule : scfg_mirror

// file: tb/scfg_strap_model.sv
/*
 * Board strap model: resistor dividers on the eight strap pins.
 * Assumes the bench picks one mode code per pin and whether fitted.
 */
`timescale 1ns/1ps

module scfg_strap_model (
	// Chosen modes, two bits a pin
	input wire logic fit_i,
	input wire logic [15:0] code_i,
	// Comparator levels seen by the device
	output logic [23:0] lvl_o
);
	// Open pins fall to mode 1 through the internal pull-down
	always_comb begin
		for (int n = 0; n < 8; n++) begin
			lvl_o[n*3 +: 3] = 3'h0;
			if (fit_i)
				lvl_o[n*3 +: 3] = 3'((4'h1 << code_i[n*2 +: 2]) - 4'h1);
		end
	end
endmodule : scfg_strap_model

// file: tb/scfg_top_tb.sv
/*
 * Self-checking bench of the strap configuration block.
 * Assumes the board strap model; the bench acts as software.
 */
`timescale 1ns/1ps

module scfg_top_tb;
	typedef struct {string n; logic [31:0] v;} scfg_note_s;
	scfg_note_s notes[$];
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, seed = 32'h96A2;
	logic wb_ack_o, fit = 1'b0, gig = 1'b0;
	logic [15:0] code = 16'h0;
	logic [23:0] lvl;
	logic [3:0] station_addr_o;
	logic aneg_disable_o, mirror_en_o, sgmii_en_o;
	logic [2:0] adv_ability_o, rx_skew_o, tx_skew_o, rx_delay_o, tx_delay_o;
	logic [3:0][7:0] tx_lane_i = '0, rx_lane_i = '0, tx_phy_o, rx_log_o;
	int failures = 0, n_compared = 0;

	always #4 clk_i = ~clk_i;

	scfg_strap_model board (.fit_i(fit), .code_i(code), .lvl_o(lvl));

	scfg_top DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.rx_lane0_strap_i(lvl[2:0]), .rx_lane2_strap_i(lvl[5:3]),
		.rx_ctrl_strap_i(lvl[8:6]), .gpio0_strap_i(lvl[11:9]),
		.gpio1_strap_i(lvl[14:12]), .indicator_pin_two_i(lvl[17:15]),
		.indicator_pin_one_i(lvl[20:18]), .indicator_pin_zero_i(lvl[23:21]),
		.station_addr_o, .aneg_disable_o, .adv_ability_o, .rx_skew_o,
		.tx_skew_o, .rx_delay_o, .tx_delay_o, .mirror_en_o, .sgmii_en_o,
		.gig_mode_i(gig), .tx_lane_i, .rx_lane_i, .tx_phy_o, .rx_log_o);

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	// Steps fall from 2.0 ns, code 4 is zero, then wrap down from 3.5 ns
	function automatic logic [2:0] dl(input logic [2:0] c);
		return 3'(c[2] ? 4'hC - 4'(c) : 4'h4 - 4'(c));
	endfunction : dl

	// Config word that the held strap codes should produce
	function automatic logic [31:0] cf(input logic [15:0] c);
		return {21'h0, c[12], c[11:10], 1'b0, c[9:8], c[7], 1'b0, c[14],
			c[13], c[5:4] == 2'h3};
	endfunction : cf

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task stop_test();
		if (failures == 0 && n_compared > 0 && notes.size() == 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test

	// Classic single cycle; the wait for ack is bounded
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int k;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		for (k = 0; k < 20; k++) begin
			@(posedge clk_i);
			if (wb_ack_o)
				break;
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (k == 20) begin
			failures++;
			stop_test();
		end
	endtask : bus

	task rd(input string n, input logic [7:0] a, input logic [31:0] e);
		notes.push_back('{n, e});
		bus(1'b0, a, 32'h0, 4'hF);
	endtask : rd

	task hard(input logic f, input logic [15:0] c);
		@(posedge clk_i);
		fit <= f;
		code <= c;
		rst_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (6) @(posedge clk_i);
	endtask : hard

	// Waits out the register pipeline before looking at settings
	task outs(input logic [3:0] a, input logic [31:0] c, input logic m,
		input logic k);
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
		chk("addr", station_addr_o, a);
		chk("aneg", aneg_disable_o, c[0] & k);
		chk("adv", adv_ability_o, c[1] ? 3'h6 : 3'h7);
		chk("rx skew", rx_skew_o, c[6:4]);
		chk("tx skew", tx_skew_o, c[10:8]);
		chk("rx delay", rx_delay_o, dl(c[6:4]));
		chk("tx delay", tx_delay_o, dl(c[10:8]));
		chk("mirror", mirror_en_o, m);
		chk("sgmii", sgmii_en_o, c[2]);
	endtask : outs

	task lanes(input logic m, input logic g);
		logic [3:0][7:0] t, r, et, er;
		@(posedge clk_i);
		seed = xs(seed);
		t = seed;
		seed = xs(seed);
		r = seed;
		tx_lane_i <= t;
		rx_lane_i <= r;
		gig <= g;
		// Mirrored slow speed uses only two pairs; the rest stay quiet
		for (int i = 0; i < 4; i++) begin
			et[i] = !m ? t[i] : (g || i > 1) ? t[3-i] : 8'h0;
			er[i] = !m ? r[i] : (g || i < 2) ? r[3-i] : 8'h0;
		end
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		chk("tx lanes", tx_phy_o, et);
		chk("rx lanes", rx_log_o, er);
	endtask : lanes

	// Read data is matched in issue order against the notes
	always @(posedge clk_i) begin
		if (wb_ack_o && !wb_we_i && notes.size() > 0) begin
			chk(notes[0].n, wb_dat_o, notes[0].v);
			void'(notes.pop_front());
		end
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		failures++;
		stop_test();
	end

	initial begin
		logic [15:0] c;
		logic [31:0] d;
		hard(1'b0, 16'h0);
		outs(4'h0, 32'h0, 1'b0, 1'b1);
		rd("strap", 8'h0C, 32'h10000);
		for (int k = 0; k < 3; k++) begin
			seed = xs(seed);
			c = {seed[15:8], seed[17], 1'b0, 1'b1, seed[16], seed[3:0]};
			hard(1'b1, c);
			outs(c[3:0], cf(c), c[15], 1'b1);
			rd("strap", 8'h0C, {16'h0, c});
			rd("cfg four", 8'hC4, {24'h0, 1'b1, 6'h0, c[15]});
			code <= ~c;
			seed = xs(seed);
			d = seed & 32'h777;
			bus(1'b1, 8'h04, {28'h0, ~c[3:0]}, 4'h1);
			bus(1'b1, 8'h04, 32'hF, 4'h2);
			bus(1'b1, 8'h08, d, 4'hF);
			outs(~c[3:0], d, c[15], 1'b1);
			rd("cfg", 8'h08, d);
			bus(1'b1, 8'h00, 32'h8000, 4'h2);
			outs(c[3:0], cf(c), c[15], 1'b1);
			rd("strap", 8'h0C, {16'h0, c});
			rd("ctrl", 8'h00, 32'h0);
		end
		bus(1'b1, 8'h08, 32'h1, 4'hF);
		bus(1'b1, 8'hC4, 32'h1, 4'h1);
		outs(c[3:0], 32'h1, 1'b1, 1'b0);
		rd("cfg four", 8'hC4, 32'h1);
		lanes(1'b1, 1'b0);
		lanes(1'b1, 1'b1);
		bus(1'b1, 8'hC4, 32'h80, 4'h1);
		outs(c[3:0], 32'h1, 1'b0, 1'b1);
		lanes(1'b0, 1'b1);
		lanes(1'b0, 1'b0);
		bus(1'b1, 8'h0C, 32'hFFFFFFFF, 4'hF);
		rd("strap ro", 8'h0C, {16'h0, c});
		rd("unmapped", 8'h40, 32'h0);
		hard(1'b1, 16'h0040);
		rd("strap bad", 8'h0C, 32'h30040);
		rd("delay", 8'h10, 32'h44);
		repeat (2) @(posedge clk_i);
		stop_test();
	end
endmodule : scfg_top_tb
